// file: timer16_waveform_output_control.sv
// Purpose: Control registers and waveform decode of the 16-bit timer
// Assumes: APB slave, zero wait states, counter datapath outside
// Notes: Mode decode feeds the counter datapath outside
`timescale 1ns/1ps
module timer16_waveform_output_control
	import timer16_wave_pkg::*;
(
	input  wire logic          CLK,
	input  wire logic          ARST_N,
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [11:0]   PADDR,
	input  wire logic [31:0]   PWDATA,
	input  wire logic [3:0]    PSTRB,
	output logic [31:0]        PRDATA,
	output logic               PREADY,
	output logic               PSLVERR,
	input  wire logic [15:0]   COUNTER_VALUE,
	input  wire logic [15:0]   CHAN_A_COMPARE_VALUE,
	input  wire logic [15:0]   CHAN_B_COMPARE_VALUE,
	input  wire logic [15:0]   CAPTURE_VALUE,
	input  wire timer_event_t  TIMER_EVENT,
	output mode_info_t         MODE_INFO,
	output logic               TOP_REACHED,
	output logic               CHAN_A_WAVE_OUT,
	output logic               CHAN_B_WAVE_OUT,
	output logic               CHAN_A_PIN_OVERRIDE,
	output logic               CHAN_B_PIN_OVERRIDE
);

	// Fixed top of modes that define it themselves
	function automatic logic [15:0] fixed_top(input logic [3:0] mode);
		case (mode)
			MODE_PC8, MODE_FAST8:   fixed_top = TOP_8BIT;
			MODE_PC9, MODE_FAST9:   fixed_top = TOP_9BIT;
			MODE_PC10, MODE_FAST10: fixed_top = TOP_10BIT;
			default:                fixed_top = COUNT_MAX;
		endcase
	endfunction

	// Address decode, shared by read and write paths
	function automatic logic is_mapped(input logic [11:0] adr);
		is_mapped = (adr == OUTPUT_MODE_CONTROL_ADR) ||
			(adr == CLOCK_MODE_CONTROL_ADR) ||
			(adr == WAVE_STATUS_ADR);
	endfunction

	logic [7:0]  timer16_output_mode_control;
	logic [7:0]  timer16_clock_mode_control;
	logic [1:0]  chan_a_output_action;
	logic [1:0]  chan_b_output_action;
	logic [3:0]  waveform_mode_select;
	logic        wr_access;
	logic        rd_setup;
	logic [31:0] next_prdata;
	logic [7:0]  wave_status;
	mode_info_t  next_mode;
	logic        toggle_a_ok;
	logic [15:0] compare_value [2];
	logic [1:0]  action [2];
	logic [1:0]  toggle_ok;
	logic [1:0]  match;
	logic [1:0]  cmp_eq_top;
	logic [1:0]  cmp_eq_bottom;
	logic [1:0]  wave;
	logic [1:0]  connected;

	// Field extraction
	assign chan_a_output_action = timer16_output_mode_control[CHAN_A_ACTION_LSB +: 2];
	assign chan_b_output_action = timer16_output_mode_control[CHAN_B_ACTION_LSB +: 2];
	assign waveform_mode_select = {timer16_clock_mode_control[MODE_HIGH_LSB +: 2],
		timer16_output_mode_control[MODE_LOW_LSB +: 2]};

	// APB handshake, always ready
	assign wr_access = PSEL && PENABLE && PWRITE && PSTRB[0] && is_mapped(PADDR);
	assign rd_setup  = PSEL && !PENABLE && !PWRITE;
	assign PREADY    = 1'b1;
	assign PSLVERR   = PSEL && PENABLE && !is_mapped(PADDR);

	// First control register
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			timer16_output_mode_control <= OUTPUT_MODE_CONTROL_RST;
		else if (wr_access && PADDR == OUTPUT_MODE_CONTROL_ADR)
			timer16_output_mode_control <= PWDATA[7:0] & OUTPUT_MODE_CONTROL_MSK;
	end

	// Second control register, only the high mode bits live here
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			timer16_clock_mode_control <= CLOCK_MODE_CONTROL_RST;
		else if (wr_access && PADDR == CLOCK_MODE_CONTROL_ADR)
			timer16_clock_mode_control <= PWDATA[7:0] & CLOCK_MODE_CONTROL_MSK;
	end

	// Live state seen by software
	assign wave_status = {2'h0, next_mode.counter_stop, TIMER_EVENT.count_up,
		connected[1], connected[0], wave[1], wave[0]};

	// Read mux
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		case (PADDR)
			OUTPUT_MODE_CONTROL_ADR: next_prdata[7:0] = timer16_output_mode_control;
			CLOCK_MODE_CONTROL_ADR:  next_prdata[7:0] = timer16_clock_mode_control;
			WAVE_STATUS_ADR:         next_prdata[7:0] = wave_status;
			default:                 next_prdata = 32'h0000_0000;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			PRDATA <= 32'h0000_0000;
		else if (rd_setup)
			PRDATA <= next_prdata;
	end

	// Mode decode: family, top, update and overflow points
	always_comb
	begin
		next_mode                = '0;
		next_mode.wave_class     = CLASS_NON_PWM;
		next_mode.top_source     = TOP_FIXED;
		next_mode.top_value      = fixed_top(waveform_mode_select);
		next_mode.compare_update = AT_IMMEDIATE;
		next_mode.overflow_point = AT_MAX;
		case (waveform_mode_select)
			MODE_NORMAL:
				next_mode.wave_class = CLASS_NON_PWM;
			MODE_CTC_A:
				next_mode.top_source = TOP_CHAN_A;
			MODE_CTC_CAPTURE:
				next_mode.top_source = TOP_CAPTURE;
			MODE_PC8, MODE_PC9, MODE_PC10:
			begin
				next_mode.wave_class     = CLASS_DUAL;
				next_mode.compare_update = AT_TOP;
				next_mode.overflow_point = AT_BOTTOM;
			end
			MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP, MODE_FAST_A:
			begin
				next_mode.wave_class     = CLASS_FAST;
				next_mode.compare_update = AT_BOTTOM;
				next_mode.overflow_point = AT_TOP;
			end
			MODE_PFC_CAPTURE, MODE_PFC_A:
			begin
				next_mode.wave_class     = CLASS_DUAL;
				next_mode.compare_update = AT_BOTTOM;
				next_mode.overflow_point = AT_BOTTOM;
			end
			MODE_PC_CAPTURE, MODE_PC_A:
			begin
				next_mode.wave_class     = CLASS_DUAL;
				next_mode.compare_update = AT_TOP;
				next_mode.overflow_point = AT_BOTTOM;
			end
			MODE_RESERVED:
			begin
				next_mode.wave_class   = CLASS_RESERVED;
				next_mode.counter_stop = 1'b1;
			end
			default:
				next_mode.wave_class = CLASS_NON_PWM;
		endcase
		// Variable tops of the fast and dual-slope families
		if (waveform_mode_select == MODE_FAST_A || waveform_mode_select == MODE_PFC_A ||
			waveform_mode_select == MODE_PC_A)
			next_mode.top_source = TOP_CHAN_A;
		if (waveform_mode_select == MODE_FAST_CAP || waveform_mode_select == MODE_PFC_CAPTURE ||
			waveform_mode_select == MODE_PC_CAPTURE)
			next_mode.top_source = TOP_CAPTURE;
		case (next_mode.top_source)
			TOP_CHAN_A:  next_mode.top_value = CHAN_A_COMPARE_VALUE;
			TOP_CAPTURE: next_mode.top_value = CAPTURE_VALUE;
			default:     next_mode.top_value = fixed_top(waveform_mode_select);
		endcase
		next_mode.dual_slope = (next_mode.wave_class == CLASS_DUAL);
	end

	assign MODE_INFO = next_mode;

	// Turning point of the count sequence
	assign TOP_REACHED = (COUNTER_VALUE == next_mode.top_value);

	// Channel A toggle permission by family
	always_comb
	begin
		toggle_a_ok = 1'b0;
		case (next_mode.wave_class)
			CLASS_NON_PWM:
				toggle_a_ok = 1'b1;
			CLASS_FAST:
				toggle_a_ok = (waveform_mode_select == MODE_FAST_CAP) ||
					(waveform_mode_select == MODE_FAST_A);
			CLASS_DUAL:
				toggle_a_ok = (waveform_mode_select == MODE_PFC_A) ||
					(waveform_mode_select == MODE_PC_A);
			default:
				toggle_a_ok = 1'b0;
		endcase
	end

	// Per-channel inputs, channel A at index 0
	assign compare_value[0] = CHAN_A_COMPARE_VALUE;
	assign compare_value[1] = CHAN_B_COMPARE_VALUE;
	assign action[0]        = chan_a_output_action;
	assign action[1]        = chan_b_output_action;
	assign toggle_ok[0]     = toggle_a_ok;
	assign toggle_ok[1]     = (next_mode.wave_class == CLASS_NON_PWM);
	assign match[0]         = TIMER_EVENT.match_a;
	assign match[1]         = TIMER_EVENT.match_b;

	// Compare output units
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			assign cmp_eq_top[ch]    = (compare_value[ch] == next_mode.top_value);
			assign cmp_eq_bottom[ch] = (compare_value[ch] == COUNT_BOTTOM);

			timer16_wave_unit u_wave (
				.CLK           (CLK),
				.ARST_N        (ARST_N),
				.WAVE_CLASS    (next_mode.wave_class),
				.ACTION        (action[ch]),
				.TOGGLE_OK     (toggle_ok[ch]),
				.MATCH         (match[ch]),
				.AT_BOTTOM     (TIMER_EVENT.at_bottom),
				.COUNT_UP      (TIMER_EVENT.count_up),
				.CMP_EQ_TOP    (cmp_eq_top[ch]),
				.CMP_EQ_BOTTOM (cmp_eq_bottom[ch]),
				.WAVE          (wave[ch]),
				.CONNECTED     (connected[ch])
			);
		end
	endgenerate

	// Pin takeover; direction bit stays with the port logic
	assign CHAN_A_PIN_OVERRIDE = connected[0];
	assign CHAN_B_PIN_OVERRIDE = connected[1];
	assign CHAN_A_WAVE_OUT     = wave[0];
	assign CHAN_B_WAVE_OUT     = wave[1];

endmodule

// file: timer16_wave_pkg.sv
// Purpose: Shared constants and types of the 16-bit timer output control
// Assumes: APB register index times four gives the byte address
// Notes: Mode codes follow the 4-bit waveform mode selector
package timer16_wave_pkg;

	// Register indices and byte addresses
	localparam logic [11:0] OUTPUT_MODE_CONTROL_IDX = 12'h080;
	localparam logic [11:0] CLOCK_MODE_CONTROL_IDX  = 12'h081;
	localparam logic [11:0] WAVE_STATUS_IDX         = 12'h090;
	localparam logic [11:0] OUTPUT_MODE_CONTROL_ADR = 12'(OUTPUT_MODE_CONTROL_IDX * 4);
	localparam logic [11:0] CLOCK_MODE_CONTROL_ADR  = 12'(CLOCK_MODE_CONTROL_IDX * 4);
	localparam logic [11:0] WAVE_STATUS_ADR         = 12'(WAVE_STATUS_IDX * 4);

	// Field positions
	localparam int CHAN_A_ACTION_LSB = 6;
	localparam int CHAN_B_ACTION_LSB = 4;
	localparam int MODE_LOW_LSB      = 0;
	localparam int MODE_HIGH_LSB     = 3;

	// Reset values and masks
	localparam logic [7:0] OUTPUT_MODE_CONTROL_RST = 8'h00;
	localparam logic [7:0] OUTPUT_MODE_CONTROL_MSK = 8'hF3;
	localparam logic [7:0] CLOCK_MODE_CONTROL_RST  = 8'h00;
	localparam logic [7:0] CLOCK_MODE_CONTROL_MSK  = 8'h18;

	// Counter limits
	localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [15:0] TOP_8BIT     = 16'h00FF;
	localparam logic [15:0] TOP_9BIT     = 16'h01FF;
	localparam logic [15:0] TOP_10BIT    = 16'h03FF;

	// Output action codes
	localparam logic [1:0] ACTION_OFF    = 2'h0;
	localparam logic [1:0] ACTION_TOGGLE = 2'h1;

	// Waveform modes
	localparam logic [3:0] MODE_NORMAL      = 4'h0;
	localparam logic [3:0] MODE_PC8         = 4'h1;
	localparam logic [3:0] MODE_PC9         = 4'h2;
	localparam logic [3:0] MODE_PC10        = 4'h3;
	localparam logic [3:0] MODE_CTC_A       = 4'h4;
	localparam logic [3:0] MODE_FAST8       = 4'h5;
	localparam logic [3:0] MODE_FAST9       = 4'h6;
	localparam logic [3:0] MODE_FAST10      = 4'h7;
	localparam logic [3:0] MODE_PFC_CAPTURE = 4'h8;
	localparam logic [3:0] MODE_PFC_A       = 4'h9;
	localparam logic [3:0] MODE_PC_CAPTURE  = 4'hA;
	localparam logic [3:0] MODE_PC_A        = 4'hB;
	localparam logic [3:0] MODE_CTC_CAPTURE = 4'hC;
	localparam logic [3:0] MODE_RESERVED    = 4'hD;
	localparam logic [3:0] MODE_FAST_CAP    = 4'hE;
	localparam logic [3:0] MODE_FAST_A      = 4'hF;

	// Waveform family, one-hot
	typedef enum logic [3:0] {
		CLASS_NON_PWM  = 4'b0001,
		CLASS_FAST     = 4'b0010,
		CLASS_DUAL     = 4'b0100,
		CLASS_RESERVED = 4'b1000
	} wave_class_t;

	typedef enum logic [1:0] {
		TOP_FIXED   = 2'h0,
		TOP_CHAN_A  = 2'h1,
		TOP_CAPTURE = 2'h2
	} top_source_t;

	typedef enum logic [1:0] {
		AT_IMMEDIATE = 2'h0,
		AT_TOP       = 2'h1,
		AT_BOTTOM    = 2'h2,
		AT_MAX       = 2'h3
	} event_point_t;

	// Decoded mode handed to the counter datapath
	typedef struct packed {
		wave_class_t  wave_class;
		top_source_t  top_source;
		logic [15:0]  top_value;
		event_point_t compare_update;
		event_point_t overflow_point;
		logic         dual_slope;
		logic         counter_stop;
	} mode_info_t;

	// Events from the counter datapath
	typedef struct packed {
		logic count_up;
		logic at_bottom;
		logic match_a;
		logic match_b;
	} timer_event_t;

endpackage

// file: timer16_wave_unit.sv
// Purpose: One compare output channel of the 16-bit timer
// Assumes: Match and bottom inputs are one-cycle strobes
// Notes: Holds its level while disconnected
`timescale 1ns/1ps
module timer16_wave_unit
	import timer16_wave_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire wave_class_t WAVE_CLASS,
	input  wire logic [1:0]  ACTION,
	input  wire logic        TOGGLE_OK,
	input  wire logic        MATCH,
	input  wire logic        AT_BOTTOM,
	input  wire logic        COUNT_UP,
	input  wire logic        CMP_EQ_TOP,
	input  wire logic        CMP_EQ_BOTTOM,
	output logic             WAVE,
	output logic             CONNECTED
);

	logic toggle_sel;

	// Toggle code only counts where the mode permits it
	assign toggle_sel = (ACTION == ACTION_TOGGLE) && TOGGLE_OK;

	// Connection decode
	always_comb
	begin
		CONNECTED = 1'b0;
		if (ACTION != ACTION_OFF && WAVE_CLASS != CLASS_RESERVED)
			CONNECTED = ACTION[1] || toggle_sel;
	end

	// Output level per waveform family
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			WAVE <= 1'b0;
		else if (CONNECTED)
		begin
			case (WAVE_CLASS)
				CLASS_NON_PWM:
				begin
					if (MATCH)
						WAVE <= ACTION[1] ? ACTION[0] : !WAVE;
				end
				CLASS_FAST:
				begin
					if (!ACTION[1])
					begin
						if (MATCH)
							WAVE <= !WAVE;
					end
					else if (MATCH && !CMP_EQ_TOP)
						WAVE <= ACTION[0];
					else if (AT_BOTTOM)
						WAVE <= !ACTION[0];
				end
				CLASS_DUAL:
				begin
					if (!ACTION[1])
					begin
						if (MATCH)
							WAVE <= !WAVE;
					end
					else if (CMP_EQ_BOTTOM)
						WAVE <= ACTION[0];
					else if (CMP_EQ_TOP)
						WAVE <= !ACTION[0];
					else if (MATCH)
						WAVE <= COUNT_UP ? ACTION[0] : !ACTION[0];
				end
				default:
					WAVE <= WAVE;
			endcase
		end
	end

endmodule

// file: timer16_pin_model.sv
// Purpose: Port pin beside one compare output
// Assumes: Pin has a pull-up while its driver is off
// Notes: Direction bit belongs to software
`timescale 1ns/1ps
module timer16_pin_model
(
	input  wire logic OVERRIDE,
	input  wire logic WAVE,
	input  wire logic DIR_OUT,
	input  wire logic PORT_DATA,
	output logic      PIN
);
	// Driver only when direction is output, wave only when overridden
	assign PIN = !DIR_OUT ? 1'b1 : (OVERRIDE ? WAVE : PORT_DATA);
endmodule

// file: timer16_wave_sva.sv
// Purpose: Port checks of the timer output control
// Assumes: Shadow registers follow APB writes
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module timer16_wave_sva
	import timer16_wave_pkg::*;
(
	input wire logic         CLK,
	input wire logic         ARST_N,
	input wire logic         PSEL,
	input wire logic         PENABLE,
	input wire logic         PWRITE,
	input wire logic [11:0]  PADDR,
	input wire logic [31:0]  PWDATA,
	input wire logic [3:0]   PSTRB,
	input wire logic [31:0]  PRDATA,
	input wire logic [15:0]  CHAN_A_COMPARE_VALUE,
	input wire timer_event_t TIMER_EVENT,
	input wire mode_info_t   MODE_INFO,
	input wire logic         CHAN_A_WAVE_OUT,
	input wire logic         CHAN_A_PIN_OVERRIDE,
	input wire logic         CHAN_B_PIN_OVERRIDE
);
	logic [7:0] shad_a;
	logic [7:0] shad_b;
	logic [3:0] mode;
	logic       wr;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// Shadow of both control registers
	assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			shad_a <= 8'h00;
			shad_b <= 8'h00;
		end
		else if (wr && PADDR == OUTPUT_MODE_CONTROL_ADR)
			shad_a <= PWDATA[7:0];
		else if (wr && PADDR == CLOCK_MODE_CONTROL_ADR)
			shad_b <= PWDATA[7:0];
	end
	assign mode = {shad_b[4:3], shad_a[1:0]};
	// Register, pin routing and mode decode
	a_unused_read_zero: assert property (PSEL && !PENABLE && !PWRITE
		&& PADDR == OUTPUT_MODE_CONTROL_ADR |=> PRDATA[31:8] == 24'h0 && PRDATA[3:2] == 2'b00)
		else $error("unused bits read nonzero");
	a_chan_a_off: assert property (shad_a[7:6] == 2'b00 |-> !CHAN_A_PIN_OVERRIDE)
		else $error("channel A connected with action off");
	a_chan_a_route: assert property (shad_a[7] && mode != MODE_RESERVED |-> CHAN_A_PIN_OVERRIDE)
		else $error("channel A not routed");
	a_chan_b_route: assert property (shad_a[5] && mode != MODE_RESERVED |-> CHAN_B_PIN_OVERRIDE)
		else $error("channel B not routed");
	a_reserved_idle: assert property (mode == MODE_RESERVED |->
		!CHAN_A_PIN_OVERRIDE && !CHAN_B_PIN_OVERRIDE && MODE_INFO.counter_stop)
		else $error("reserved mode not idle");
	a_normal_decode: assert property (mode == MODE_NORMAL |->
		MODE_INFO.top_value == COUNT_MAX && MODE_INFO.overflow_point == AT_MAX)
		else $error("normal mode decode wrong");
	// Wave reactions to events
	a_toggle_match: assert property (MODE_INFO.wave_class == CLASS_NON_PWM
		&& shad_a[7:6] == ACTION_TOGGLE && TIMER_EVENT.match_a
		|=> CHAN_A_WAVE_OUT != $past(CHAN_A_WAVE_OUT)) else $error("no toggle on match");
	a_fast_clear: assert property (MODE_INFO.wave_class == CLASS_FAST && shad_a[7:6] == 2'b10
		&& TIMER_EVENT.match_a && CHAN_A_COMPARE_VALUE != MODE_INFO.top_value
		|=> !CHAN_A_WAVE_OUT) else $error("fast match did not clear");
	a_dual_up_set: assert property (MODE_INFO.wave_class == CLASS_DUAL && shad_a[7:6] == 2'b11
		&& TIMER_EVENT.match_a && TIMER_EVENT.count_up && CHAN_A_COMPARE_VALUE != 16'h0000
		&& CHAN_A_COMPARE_VALUE != MODE_INFO.top_value |=> CHAN_A_WAVE_OUT)
		else $error("dual up match did not set");
	c_reserved: cover property (mode == MODE_RESERVED);
	c_fast_match: cover property (MODE_INFO.wave_class == CLASS_FAST && TIMER_EVENT.match_a);
	c_dual_match: cover property (MODE_INFO.wave_class == CLASS_DUAL && TIMER_EVENT.match_a);
endmodule

bind timer16_waveform_output_control timer16_wave_sva chk (.CLK(CLK), .ARST_N(ARST_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PSTRB(PSTRB), .PRDATA(PRDATA), .CHAN_A_COMPARE_VALUE(CHAN_A_COMPARE_VALUE),
	.TIMER_EVENT(TIMER_EVENT), .MODE_INFO(MODE_INFO), .CHAN_A_WAVE_OUT(CHAN_A_WAVE_OUT),
	.CHAN_A_PIN_OVERRIDE(CHAN_A_PIN_OVERRIDE), .CHAN_B_PIN_OVERRIDE(CHAN_B_PIN_OVERRIDE));

// file: timer16_waveform_output_control_tb_top.sv
// Purpose: Register, decode and wave tests of the timer output control
// Assumes: Zero wait state slave, events driven by the bench
// Notes: Pin model shows the effect of the direction bit
`timescale 1ns/1ps
module timer16_waveform_output_control_tb_top
	import timer16_wave_pkg::*;
;
	logic         clk, arst_n, psel, penable, pwrite, pready, pslverr, err, p, top_hit;
	logic         wave_a, wave_b, ovr_a, ovr_b, dir_out, pin;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [3:0]   pstrb;
	logic [15:0]  cmp_a, cmp_b, cap, cnt;
	timer_event_t ev;
	mode_info_t   info;
	int           bad_count, check_count;
	logic [15:0]  tops [16] = '{16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF, 16'h1234, 16'h00FF,
		16'h01FF, 16'h03FF, 16'h0567, 16'h1234, 16'h0567, 16'h1234, 16'h0567, 16'hFFFF,
		16'h0567, 16'h1234};
	// Clock
	always #2.5 clk = ~clk;
	timer16_waveform_output_control uut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COUNTER_VALUE(cnt),
		.CHAN_A_COMPARE_VALUE(cmp_a), .CHAN_B_COMPARE_VALUE(cmp_b), .CAPTURE_VALUE(cap),
		.TIMER_EVENT(ev), .MODE_INFO(info), .TOP_REACHED(top_hit), .CHAN_A_WAVE_OUT(wave_a),
		.CHAN_B_WAVE_OUT(wave_b), .CHAN_A_PIN_OVERRIDE(ovr_a), .CHAN_B_PIN_OVERRIDE(ovr_b));
	timer16_pin_model pin_a (.OVERRIDE(ovr_a), .WAVE(wave_a), .DIR_OUT(dir_out),
		.PORT_DATA(1'b0), .PIN(pin));
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer, outputs settled on return
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		pstrb <= {4{w}};
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic setup(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] bb);
		xfer(1'b1, OUTPUT_MODE_CONTROL_ADR, {aa, bb, 2'b00, m[1:0]});
		xfer(1'b1, CLOCK_MODE_CONTROL_ADR, {3'b000, m[3:2], 3'b000});
	endtask
	// One-cycle event, wave settled on return
	task automatic pulse(input logic [3:0] e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 4'h0;
		#1;
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#100000;
		bad_count++;
		conclude();
	end
	initial
	begin
		{clk, arst_n, psel, penable, pwrite, dir_out} = 6'b000000;
		{paddr, pwdata, pstrb, ev, cnt} = '0;
		{cmp_a, cmp_b, cap} = {16'h1234, 16'h0080, 16'h0567};
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		xfer(1'b0, OUTPUT_MODE_CONTROL_ADR, 8'h00);
		chk("ctrl_a reset", 32'h0, rd);
		xfer(1'b0, CLOCK_MODE_CONTROL_ADR, 8'h00);
		chk("ctrl_b reset", 32'h0, rd);
		xfer(1'b1, OUTPUT_MODE_CONTROL_ADR, 8'hFF);
		xfer(1'b1, CLOCK_MODE_CONTROL_ADR, 8'hFF);
		xfer(1'b0, OUTPUT_MODE_CONTROL_ADR, 8'h00);
		chk("ctrl_a mask", 32'hF3, rd);
		xfer(1'b0, CLOCK_MODE_CONTROL_ADR, 8'h00);
		chk("ctrl_b mask", 32'h18, rd);
		xfer(1'b0, 12'h300, 8'h00);
		chk("unmapped err", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		// Every mode with toggle code on both channels
		for (int m = 0; m < 16; m++)
		begin
			cnt <= tops[m];
			setup(m[3:0], 2'b01, 2'b01);
			chk("top", tops[m], info.top_value);
			chk("top hit", 32'h1, top_hit);
			chk("source", 32'h62660100 >> (2 * m) & 3, info.top_source);
			chk("update", (m == 13) ? 2'h0 : 32'hA05AA854 >> (2 * m) & 3, info.compare_update);
			chk("overflow", 32'h5FAA57AB >> (2 * m) & 3, info.overflow_point);
			chk("dual", 32'(16'h0F0E >> m) & 1, info.dual_slope);
			chk("stop", m == 13, info.counter_stop);
			chk("ovr_a", 32'(16'hDA11 >> m) & 1, ovr_a);
			chk("ovr_b", 32'(16'h1011 >> m) & 1, ovr_b);
		end
		// Non-PWM actions
		cmp_a <= 16'h0080;
		setup(MODE_NORMAL, 2'b01, 2'b11);
		chk("top miss", 32'h0, top_hit);
		p = wave_a;
		pulse(4'b0011);
		chk("toggle a", p ^ 1'b1, wave_a);
		chk("set b", 32'h1, wave_b);
		setup(MODE_NORMAL, 2'b00, 2'b10);
		pulse(4'b0011);
		chk("hold a", p ^ 1'b1, wave_a);
		chk("clear b", 32'h0, wave_b);
		// Fast PWM actions, then reserved-mode hold and status read
		for (int k = 0; k < 2; k++)
		begin
			setup(MODE_FAST8, {1'b1, k[0]}, 2'b00);
			pulse(4'b0100);
			chk("fast bottom", k[0] ^ 1'b1, wave_a);
			pulse(4'b0010);
			chk("fast match", k[0], wave_a);
		end
		cmp_a <= 16'h00FF;
		setup(MODE_FAST8, 2'b10, 2'b00);
		pulse(4'b0100);
		pulse(4'b0010);
		chk("top ignored", 32'h1, wave_a);
		setup(MODE_RESERVED, 2'b10, 2'b00);
		pulse(4'b0010);
		chk("reserved hold", 32'h1, wave_a);
		xfer(1'b0, WAVE_STATUS_ADR, 8'h00);
		chk("status", 32'h21, rd);
		// Dual-slope actions and extremes
		cmp_a <= 16'h0080;
		setup(MODE_PC8, 2'b10, 2'b00);
		pulse(4'b1010);
		chk("dual up clr", 32'h0, wave_a);
		pulse(4'b0010);
		chk("dual down set", 32'h1, wave_a);
		cmp_a <= 16'h0000;
		pulse(4'h0);
		chk("cmp bottom", 32'h0, wave_a);
		cmp_a <= 16'h00FF;
		pulse(4'h0);
		chk("cmp top", 32'h1, wave_a);
		cmp_a <= 16'h0080;
		setup(MODE_PC8, 2'b11, 2'b00);
		pulse(4'b0010);
		chk("dual down clr", 32'h0, wave_a);
		pulse(4'b1010);
		chk("dual up set", 32'h1, wave_a);
		pulse(4'b0010);
		chk("pin pulled", 32'h1, pin);
		dir_out <= 1'b1;
		#1;
		chk("pin driven", 32'h0, pin);
		conclude();
	end
endmodule
